// ### common/rtrim_pkg.sv
// Shared constants for the rate-trim device end and its host end.
package rtrim_pkg;

  // Oscillator ticks in one nominal second of the divider chain.
  localparam int unsigned OSC_TICKS_PER_SEC = 32768;
  // Half of a nominal second, the low phase of the 1 Hz pulse.
  localparam int unsigned HALF_SEC_TICKS = OSC_TICKS_PER_SEC / 2;
  // One trim step adds or removes one pulse of the 16.384 kHz stage, two oscillator ticks.
  localparam int unsigned STEP_TICKS = 2;
  // Correction windows in seconds for window select clear and set.
  localparam int unsigned WIN_SHORT_SEC = 20;
  localparam int unsigned WIN_LONG_SEC = 60;

  // Trim register layout.
  localparam int unsigned TRIM_WIN_BIT = 0;
  localparam int unsigned TRIM_CNT_LSB = 1;
  localparam int unsigned TRIM_CNT_W = 7;
  localparam logic [7:0] TRIM_RESET = 8'h00;
  localparam logic [7:0] TRIM_OFF = 8'h00;

  // Host trim arithmetic limits.
  localparam logic [7:0] FAST_BASE = 8'h80;
  localparam logic [6:0] FAST_MAX_STEPS = 7'h40;
  localparam logic [7:0] SLOW_MAX_COUNT = 8'h3E;

  // Host register offsets on the AHB-Lite side.
  localparam logic [7:0] HOST_CMD_OFS = 8'h00;
  localparam logic [7:0] HOST_STAT_OFS = 8'h04;
  localparam logic [7:0] HOST_PERIOD_OFS = 8'h08;

  // Host command register fields.
  localparam int unsigned CMD_STEPS_LSB = 0;
  localparam int unsigned CMD_SLOW_BIT = 7;
  localparam int unsigned CMD_LONG_BIT = 8;
  localparam int unsigned CMD_OFF_BIT = 9;
  localparam logic [9:0] CMD_RESET = 10'h000;

  // Host status register fields.
  localparam int unsigned STAT_REFUSED_BIT = 8;

  // AHB-Lite transfer type and response codes.
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HRESP_OKAY = 2'h0;

endpackage

// ### common/rtrim_if.sv
// Link between the rate-trim device and the host that programs it.
`timescale 1ns/1ps
interface rtrim_if;
  logic trim_wr;
  logic [7:0] trim_wdata;
  logic [7:0] trim_rdata;
  logic interrupt_pin_one_n;

  // Device end of the link.
  modport dev (
    input trim_wr,
    input trim_wdata,
    output trim_rdata,
    output interrupt_pin_one_n
  );

  // Host end of the link.
  modport host (
    output trim_wr,
    output trim_wdata,
    input trim_rdata,
    input interrupt_pin_one_n
  );
endinterface

// ### design/rtrim_device.sv
// Rate-trim divider chain of the real-time clock, with the 1 Hz pulse output.
//
// Design decisions made here: the trim register port on the link and the placing of the registers.
`timescale 1ns/1ps
module rtrim_device #(
  parameter int unsigned OSC_TICKS = rtrim_pkg::OSC_TICKS_PER_SEC,
  parameter int unsigned WIN_SHORT = rtrim_pkg::WIN_SHORT_SEC,
  parameter int unsigned WIN_LONG = rtrim_pkg::WIN_LONG_SEC
) (
  input wire logic hclk,
  input wire logic hresetn,
  rtrim_if.dev link,
  input wire logic osc_in,
  output logic osc_out,
  output logic sec_pulse,
  output logic [5:0] sec_in_window
);
  import rtrim_pkg::*;

  // How the trim works: the synchronised oscillator advances a sub-second counter,
  // and the counter's end point sets the length of each second. Every second of a
  // window ends after the nominal count except the last, whose end point moves by
  // two oscillator ticks for each trim step. Moving the end point early shortens
  // that second and speeds the clock up; moving it late lengthens the second.
  // The oscillator itself and its echo on osc_out are never touched, so the
  // correction is only visible on the 1 Hz pin and on sec_pulse, as one odd period per window.
  // The low half of every second has the nominal length, so the rising edge of
  // the pin stays put and only the next falling edge moves.
  // Limitation: a trim write takes effect at once. A write late in the last
  // second of a window may end that second at once, giving one period that is
  // neither nominal nor corrected; software should write just after a falling
  // edge of the pin.

  // Widths of the divider counters.
  localparam int unsigned SUB_W = 17;
  localparam int unsigned WIN_W = 6;

  // Elaboration checks: the sub-second counter must hold a full second plus the
  // largest slow-down, and the window counter must hold the longest window.
  if (OSC_TICKS < 2 * STEP_TICKS * 64) begin : g_osc_small
    $error("OSC_TICKS is too small for the full trim span.");
  end
  if (OSC_TICKS > 65000) begin : g_osc_large
    $error("OSC_TICKS does not fit the sub-second counter.");
  end
  if (WIN_SHORT < 2 || WIN_SHORT > 63) begin : g_win_short
    $error("WIN_SHORT must lie between 2 and 63 seconds.");
  end
  if (WIN_LONG < 2 || WIN_LONG > 63) begin : g_win_long
    $error("WIN_LONG must lie between 2 and 63 seconds.");
  end

  // Nominal second, half second and last index of each window, at counter width.
  localparam logic [SUB_W-1:0] SUB_NOMINAL = SUB_W'(OSC_TICKS);
  localparam logic [SUB_W-1:0] SUB_HALF = SUB_W'(OSC_TICKS / 2);
  localparam logic [WIN_W-1:0] WIN_SHORT_LAST = WIN_W'(WIN_SHORT - 1);
  localparam logic [WIN_W-1:0] WIN_LONG_LAST = WIN_W'(WIN_LONG - 1);

  logic osc_s1_q;
  logic osc_s2_q;
  logic osc_s3_q;
  logic osc_out_q;
  logic [7:0] trim_q;
  logic [SUB_W-1:0] sub_q;
  logic [SUB_W-1:0] sub_d;
  logic [WIN_W-1:0] win_q;
  logic [WIN_W-1:0] win_d;
  logic interrupt_pin_one_n_q;
  logic sec_pulse_q;

  wire osc_tick;
  wire win_long;
  wire [WIN_W-1:0] win_last;
  wire last_sec;
  wire signed [TRIM_CNT_W-1:0] trim_cnt;
  wire signed [8:0] adj_ticks;
  wire [SUB_W-1:0] corr_period;
  wire [SUB_W-1:0] cur_period;
  wire sec_end;

  // Oscillator pin passes two flops; the third flop only feeds the edge detector.
  // The pin is asynchronous to the bus clock, so nothing but the second flop reads
  // the first; the bus clock must run at least four times the oscillator rate.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
    end else begin
      osc_s1_q <= osc_in;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
    end
  end

  // One cycle per rising oscillator edge advances the divider chain.
  assign osc_tick = osc_s2_q & ~osc_s3_q;

  // The raw oscillator is echoed straight from the synchroniser, never from the trimmed chain.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_out_q <= 1'b0;
    end else begin
      osc_out_q <= osc_s2_q;
    end
  end

  // Trim register, written by the host over the link and read back unchanged.
  // The byte is kept exactly as written, so a readback shows the reversed count
  // and the window bit as they are stored.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trim_q <= TRIM_RESET;
    end else if (link.trim_wr) begin
      trim_q <= link.trim_wdata;
    end
  end

  // Un-reverse the count field: register bit 7 is count bit 0.
  genvar gi;
  generate
    for (gi = 0; gi < TRIM_CNT_W; gi++) begin : g_unrev
      assign trim_cnt[gi] = trim_q[TRIM_CNT_LSB + TRIM_CNT_W - 1 - gi];
    end
  endgenerate

  // Window length follows bit 0: clear gives the short window, set the long one.
  assign win_long = trim_q[TRIM_WIN_BIT];
  assign win_last = win_long ? WIN_LONG_LAST : WIN_SHORT_LAST;

  // A mode change mid-window is absorbed by treating any overshoot as the last second.
  assign last_sec = (win_q >= win_last);

  // Each step moves two oscillator ticks, so one step over a 20 s window is
  // 2 / (20 * 32768), about 3.052 ppm, and over 60 s about 1.017 ppm.
  // The sign extension keeps a negative count negative through the product.
  assign adj_ticks = 9'(STEP_TICKS) * {{2{trim_cnt[TRIM_CNT_W-1]}}, trim_cnt};

  // A positive count shortens the corrected second, a negative one lengthens it;
  // the count spans -64..+63 steps, which gives the documented ppm span.
  assign corr_period = SUB_NOMINAL - {{(SUB_W-9){adj_ticks[8]}}, adj_ticks};

  // Only the last second of each window is altered; all other seconds stay nominal.
  assign cur_period = last_sec ? corr_period : SUB_NOMINAL;

  // A second ends on the tick that completes its period.
  assign sec_end = osc_tick && (sub_q >= cur_period - SUB_W'(1));

  // Next values of the sub-second and in-window second counters.
  always_comb begin
    sub_d = sub_q;
    win_d = win_q;
    if (sec_end) begin
      sub_d = '0;
      win_d = last_sec ? '0 : win_q + WIN_W'(1);
    end else if (osc_tick) begin
      sub_d = sub_q + SUB_W'(1);
    end
  end

  // Divider chain state; a zero trim leaves every second nominal.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sub_q <= '0;
      win_q <= '0;
    end else begin
      sub_q <= sub_d;
      win_q <= win_d;
    end
  end

  // The 1 Hz pin is low for the first half of each second and high for the rest,
  // so its falling edges mark second boundaries and show the altered period.
  // Deciding from sub_d rather than sub_q keeps the pin in step with sec_pulse,
  // so both mark the same clock edge.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      interrupt_pin_one_n_q <= 1'b1;
      sec_pulse_q <= 1'b0;
    end else begin
      interrupt_pin_one_n_q <= (sub_d >= SUB_HALF);
      sec_pulse_q <= sec_end;
    end
  end

  // Outputs, all straight from flip-flops.
  assign link.trim_rdata = trim_q;
  assign link.interrupt_pin_one_n = interrupt_pin_one_n_q;
  assign osc_out = osc_out_q;
  assign sec_pulse = sec_pulse_q;
  assign sec_in_window = win_q;

endmodule

// ### design/rtrim_host.sv
// Host end: AHB-Lite register slave that computes and programs the trim value.
`timescale 1ns/1ps
module rtrim_host (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic [1:0] hresp,
  rtrim_if.host link
);
  import rtrim_pkg::*;

  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [9:0] cmd_q;
  logic refused_q;
  logic trim_wr_q;
  logic [7:0] trim_wdata_q;
  logic interrupt_pin_one_prev_q;
  logic [31:0] per_cnt_q;
  logic [31:0] period_q;
  logic [31:0] hrdata_q;

  wire addr_ok;
  wire [6:0] new_steps;
  wire new_slow;
  wire new_long;
  wire new_off;
  wire [7:0] fast_cnt;
  wire [7:0] slow_cnt;
  wire cnt_ok;
  wire [6:0] cnt_val;
  wire [7:0] trim_val;
  wire cmd_we;
  wire rd_take;
  wire interrupt_pin_one_fall;

  // Address phase decode; only word transfers are served.
  assign addr_ok = hsel && hready && (htrans == HTRANS_NONSEQ) && (hsize == 3'h2);
  assign rd_take = addr_ok && !hwrite;
  assign cmd_we = wr_pend_q && (wr_addr_q == HOST_CMD_OFS);

  // Split the command word being written.
  assign new_steps = hwdata[CMD_STEPS_LSB +: 7];
  assign new_slow = hwdata[CMD_SLOW_BIT];
  assign new_long = hwdata[CMD_LONG_BIT];
  assign new_off = hwdata[CMD_OFF_BIT];

  // Fast clock takes 128 minus the steps, slow clock the steps plus one.
  assign fast_cnt = FAST_BASE - {1'b0, new_steps};
  assign slow_cnt = {1'b0, new_steps} + 8'h01;
  assign cnt_ok = new_off || (new_slow ? (slow_cnt <= SLOW_MAX_COUNT)
                                       : (new_steps <= FAST_MAX_STEPS));
  assign cnt_val = new_slow ? slow_cnt[6:0] : fast_cnt[6:0];

  // Bit-reverse the count into bits 7..1 and put the window select in bit 0.
  assign trim_val = new_off ? TRIM_OFF
                            : {cnt_val[0], cnt_val[1], cnt_val[2], cnt_val[3],
                               cnt_val[4], cnt_val[5], cnt_val[6], new_long};

  // Address phase capture for the write data phase that follows.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= addr_ok && hwrite;
      wr_addr_q <= haddr;
    end
  end

  // Command write: an in-range count is sent to the device, otherwise it is refused.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_q <= CMD_RESET;
      refused_q <= 1'b0;
      trim_wr_q <= 1'b0;
      trim_wdata_q <= TRIM_RESET;
    end else begin
      trim_wr_q <= cmd_we && cnt_ok;
      if (cmd_we) begin
        cmd_q <= hwdata[9:0];
        refused_q <= !cnt_ok;
        if (cnt_ok) begin
          trim_wdata_q <= trim_val;
        end
      end
    end
  end

  // Period of the 1 Hz pin in bus clocks, falling edge to falling edge.
  assign interrupt_pin_one_fall = interrupt_pin_one_prev_q && !link.interrupt_pin_one_n;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      interrupt_pin_one_prev_q <= 1'b1;
      per_cnt_q <= 32'h00000000;
      period_q <= 32'h00000000;
    end else begin
      interrupt_pin_one_prev_q <= link.interrupt_pin_one_n;
      per_cnt_q <= interrupt_pin_one_fall ? 32'h00000001 : per_cnt_q + 32'h00000001;
      if (interrupt_pin_one_fall) begin
        period_q <= per_cnt_q;
      end
    end
  end

  // Read data is registered at the address phase and stands in the data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h00000000;
    end else if (rd_take) begin
      case (haddr)
        HOST_CMD_OFS: hrdata_q <= {22'h000000, cmd_q};
        HOST_STAT_OFS: hrdata_q <= {23'h000000, refused_q, link.trim_rdata};
        HOST_PERIOD_OFS: hrdata_q <= period_q;
        default: hrdata_q <= 32'h00000000;
      endcase
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = HRESP_OKAY;
  assign hrdata = hrdata_q;
  assign link.trim_wr = trim_wr_q;
  assign link.trim_wdata = trim_wdata_q;

endmodule

// ### dv/rtrim_chk.sv
// Concurrent checks on the link between the rate-trim device and its host.
`timescale 1ns/1ps
module rtrim_chk #(
  parameter int unsigned OSC_TICKS = 256,
  parameter int unsigned TICK_CYC = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic trim_wr,
  input wire logic [7:0] trim_wdata,
  input wire logic [7:0] trim_rdata,
  input wire logic interrupt_pin_one_n
);
  localparam int NOM = OSC_TICKS * TICK_CYC;
  localparam int LOW = NOM / 2;
  localparam int STEP = 2 * TICK_CYC;
  logic pv_q;
  logic seen_q;
  logic full_q;
  logic [15:0] per_q;
  logic [15:0] lo_q;
  logic signed [6:0] cnt;
  logic fall;
  int alt_per;
  // Un-reversed trim count and the corrected second length that it asks for.
  assign cnt = {trim_rdata[1], trim_rdata[2], trim_rdata[3], trim_rdata[4], trim_rdata[5],
    trim_rdata[6], trim_rdata[7]};
  assign alt_per = NOM - STEP * int'(cnt);
  assign fall = pv_q & ~interrupt_pin_one_n;
  // Counts the cycles of each second and of its low phase on the 1 Hz pin.
  // The first second after reset starts off the oscillator phase, so length
  // checks wait until full_q marks its end and start with the whole second after it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pv_q <= 1'h1;
      seen_q <= 1'h0;
      full_q <= 1'h0;
      per_q <= 16'h0000;
      lo_q <= 16'h0000;
    end else begin
      pv_q <= interrupt_pin_one_n;
      seen_q <= seen_q | fall;
      full_q <= full_q | (fall & seen_q);
      per_q <= fall ? 16'h0001 : per_q + 16'h0001;
      lo_q <= interrupt_pin_one_n ? 16'h0000 : lo_q + 16'h0001;
    end
  end
  default clocking dc @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  a_trim_store: assert property (trim_wr |=> trim_rdata == $past(trim_wdata))
    else $error("trim register did not take the written byte");
  a_trim_hold: assert property (!trim_wr |=> $stable(trim_rdata))
    else $error("trim register changed without a write");
  a_wdata_steady: assert property ($changed(trim_wdata) |-> trim_wr)
    else $error("trim data moved outside a write strobe");
  a_reset_trim: assert property ($rose(hresetn) |-> trim_rdata == 8'h00)
    else $error("trim register not clear after reset");
  a_low_first: assert property ($fell(interrupt_pin_one_n) |=> (!interrupt_pin_one_n)[*8])
    else $error("pulse pin rose early in a second");
  a_low_half: assert property ($rose(interrupt_pin_one_n) && full_q |-> lo_q == LOW)
    else $error("low phase of the second pulse has wrong length");
  a_period_exact: assert property (fall && full_q |-> per_q == NOM || per_q == alt_per)
    else $error("second length is neither nominal nor corrected");
  a_zero_nominal: assert property (fall && full_q && cnt == 7'h00 |-> per_q == NOM)
    else $error("second altered with a zero trim");
  cover property (trim_wr);
  cover property (fall && full_q && per_q != NOM);
  cover property ($rose(interrupt_pin_one_n));
endmodule

// ### dv/rtrim_rate_trim_test.sv
// Self-checking bench for the rate-trim host and device pair.
`timescale 1ns/1ps
module rtrim_rate_trim_test;
  import rtrim_pkg::*;
  localparam int OSC = 256;
  localparam int NOM = OSC * 8;
  logic hclk = 1'h0;
  logic hresetn = 1'h0;
  logic hsel = 1'h0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hready;
  logic [31:0] hrdata;
  logic [1:0] hresp;
  logic osc_in = 1'h0;
  logic osc_out;
  logic sec_pulse;
  logic [1:0] osc_div = 2'h0;
  logic [31:0] rd;
  logic [5:0] win;
  int errors = 0;
  int tests_run = 0;
  int per, os, sp, alt, last;
  logic [9:0] cmd_t [8] = '{10'h016, 10'h09A, 10'h140, 10'h1BD, 10'h1BE, 10'h041, 10'h200,
    10'h000};
  logic [8:0] stat_t [8] = '{9'h056, 9'h0D8, 9'h003, 9'h07D, 9'h17D, 9'h17D, 9'h000, 9'h000};
  logic [9:0] rc_t [3] = '{10'h016, 10'h1BD, 10'h140};
  int dl_t [3] = '{352, -992, 1024};
  int wn_t [3] = '{3, 5, 5};
  rtrim_if link();
  rtrim_device #(.OSC_TICKS(OSC), .WIN_SHORT(3), .WIN_LONG(5)) i_rtrim_device (
    .hclk(hclk), .hresetn(hresetn), .link(link), .osc_in(osc_in), .osc_out(osc_out),
    .sec_pulse(sec_pulse), .sec_in_window(win));
  rtrim_host i_rtrim_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hrdata(hrdata), .hresp(hresp), .link(link));
  rtrim_chk #(.OSC_TICKS(OSC), .TICK_CYC(8)) i_rtrim_chk (.hclk(hclk), .hresetn(hresetn),
    .trim_wr(link.trim_wr), .trim_wdata(link.trim_wdata), .trim_rdata(link.trim_rdata),
    .interrupt_pin_one_n(link.interrupt_pin_one_n));
  // Bus clock, and an oscillator scaled to eight bus cycles a tick.
  initial begin
    forever #4 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    osc_div <= osc_div + 2'h1;
    if (osc_div == 2'h3) begin
      osc_in <= ~osc_in;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One single AHB-Lite word transfer; read data lands in rd.
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'h1;
    haddr <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'h1);
    rd = hrdata;
    chk({30'h0, hresp}, {30'h0, HRESP_OKAY});
  endtask
  // Runs to the next fall of the pulse pin, counting cycles, oscillator rises and pulses.
  task automatic sec(output int p, output int o, output int s);
    logic pi;
    logic po;
    logic f;
    p = 0;
    o = 0;
    s = 0;
    pi = link.interrupt_pin_one_n;
    po = osc_out;
    f = 1'h0;
    while (f !== 1'h1) begin
      @(posedge hclk);
      #1;
      p++;
      o += int'(osc_out && !po);
      s += int'(sec_pulse);
      f = pi && !link.interrupt_pin_one_n;
      pi = link.interrupt_pin_one_n;
      po = osc_out;
    end
  endtask
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Cuts a hang short well after the expected run length.
  initial begin
    #800000;
    errors++;
    final_report();
  end
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'h1;
    ahb(1'h0, HOST_STAT_OFS, 32'h0);
    chk(rd, 32'h0);
    ahb(1'h0, HOST_CMD_OFS, 32'h0);
    chk(rd, {22'h0, CMD_RESET});
    ahb(1'h1, 8'h0C, 32'hFFFFFFFF);
    ahb(1'h0, 8'h0C, 32'h0);
    chk(rd, 32'h0);
    $display("test reset values done");
    // Every command form, both windows, refusals and off, read back as the trim byte.
    sec(per, os, sp);
    foreach (cmd_t[i]) begin
      ahb(1'h1, HOST_CMD_OFS, {22'h0, cmd_t[i]});
      ahb(1'h0, HOST_STAT_OFS, 32'h0);
      chk(rd, {23'h0, stat_t[i]});
    end
    $display("test trim encoding done");
    // Measures two windows per setting: one altered second per window, fixed spacing.
    foreach (rc_t[i]) begin
      sec(per, os, sp);
      ahb(1'h1, HOST_CMD_OFS, {22'h0, rc_t[i]});
      sec(per, os, sp);
      alt = 0;
      last = 0;
      for (int k = 1; k <= 2 * wn_t[i]; k++) begin
        sec(per, os, sp);
        chk(os, per / 8);
        chk(sp, 1);
        chk({31'h0, per != NOM}, {31'h0, win == 6'h00});
        if (per != NOM) begin
          chk(per, NOM + dl_t[i]);
          if (alt > 0) begin
            chk(k - last, wn_t[i]);
          end
          alt++;
          last = k;
        end
      end
      chk(alt, 2);
      ahb(1'h0, HOST_PERIOD_OFS, 32'h0);
      chk(rd, per);
    end
    $display("test rate windows done");
    final_report();
  end
endmodule
